/* File: bench/kwsc_keys.sv */
// Far-side model: four key switches and the key-reset-enable strap.
// Assumes the bench commands presses as levels; pins are pulled up.
`default_nettype none

module kwsc_keys (
  // Commands from the bench
  input  wire logic [3:0] press,
  input  wire logic       strap,
  // Pins towards the block
  output logic            key_return_input_0,
  output logic            key_return_input_1,
  output logic            key_return_input_2,
  output logic            key_return_input_3,
  output logic            key_reset_enable_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // A pressed key pulls its pin low; the pull-up holds it high otherwise.
  // The skew keeps pin changes away from the sampling edge.
  assign #3 key_return_input_0 = ~press[0];
  assign #3 key_return_input_1 = ~press[1];
  assign #3 key_return_input_2 = ~press[2];
  assign #3 key_return_input_3 = ~press[3];
  assign #3 key_reset_enable_pin = strap;
endmodule

`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the key wake-up and standby control block.
// Assumes the key model in kwsc_keys and the strobe register port.
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t mismatch got %0h exp %0h", $time, (a), (e)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import kwsc_pkg::*;
  localparam int WAITC = 10;
  logic       ref_clk, rst_n, stop_exec, halt_exec, other_irq_pending, strap, irq, clk_en;
  logic [3:0] press;
  logic [7:0] rdata;
  logic       k0, k1, k2, k3, krr;
  kwsc_bus_s  bus;
  kwsc_pwr_s  pwr;
  int         error_cnt, check_count;

  kwsc_keys u_kwsc_keys (.press(press), .strap(strap), .key_return_input_0(k0),
    .key_return_input_1(k1), .key_return_input_2(k2), .key_return_input_3(k3),
    .key_reset_enable_pin(krr));
  // Short oscillation wait keeps the run brief
  kwsc_top #(.OSC_WAIT_CYC(WAITC)) u_kwsc_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .bus(bus), .rdata(rdata), .key_return_input_0(k0),
    .key_return_input_1(k1), .key_return_input_2(k2), .key_return_input_3(k3),
    .key_reset_enable_pin(krr), .stop_exec(stop_exec), .halt_exec(halt_exec),
    .other_irq_pending(other_irq_pending), .pwr(pwr), .irq(irq));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    `CHK(rdata & m, e)
  endtask

  task automatic pulse(input logic stp);
    @(posedge ref_clk);
    if (stp) stop_exec <= 1'b1;
    else halt_exec <= 1'b1;
    @(posedge ref_clk);
    stop_exec <= 1'b0;
    halt_exec <= 1'b0;
    #1;
  endtask

  // Counts oscillator-running, processor-stopped cycles until the processor runs
  task automatic wait_run(output int n);
    int i;
    n = 0;
    for (i = 0; i < 100 && pwr.cpu_clk_en !== 1'b1; i++) begin
      if (pwr.osc_en === 1'b1) n++;
      cyc(1);
    end
    if (i == 100) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic t_reset();
    chk_reg(KWSC_ADDR_SELECT, 8'hFF, 8'h00);
    chk_reg(KWSC_ADDR_PCC, 8'hFF, 8'h00);
    chk_reg(4'hF, 8'hFF, 8'h00);
    `CHK(pwr.osc_en, 1'b1)
    `CHK(pwr.cpu_clk_en, 1'b1)
    `CHK(irq, 1'b0)
  endtask

  task automatic t_edge();
    press <= 4'h1;
    cyc(6);
    chk_reg(KWSC_ADDR_FLAGS, 8'h01, 8'h00);
    press <= 4'h0;
    // Select change with the input disabled, then clear the request
    wr(KWSC_ADDR_SELECT, {4'h0, KWSC_SEL_ALL_KEYS});
    wr(KWSC_ADDR_FLAGS, 8'h00);
    press <= 4'h4;
    cyc(6);
    press <= 4'h0;
    cyc(20);
    chk_reg(KWSC_ADDR_FLAGS, 8'h03, 8'h01);
    chk_reg(KWSC_ADDR_IRQ_ST, 8'h01, 8'h01);
    wr(KWSC_ADDR_FLAGS, 8'h00);
    chk_reg(KWSC_ADDR_FLAGS, 8'h01, 8'h00);
  endtask

  task automatic t_irq();
    wr(KWSC_ADDR_IRQ_MK, 8'h01);
    cyc(1);
    `CHK(irq, 1'b1)
    wr(KWSC_ADDR_IRQ_MK, 8'h00);
    cyc(1);
    `CHK(irq, 1'b0)
    wr(KWSC_ADDR_IRQ_MK, 8'h01);
    wr(KWSC_ADDR_IRQ_ST, 8'h07);
    cyc(1);
    `CHK(irq, 1'b0)
    chk_reg(KWSC_ADDR_IRQ_ST, 8'h07, 8'h00);
  endtask

  task automatic t_block();
    press <= 4'h1;
    cyc(6);
    wr(KWSC_ADDR_FLAGS, 8'h00);
    press <= 4'h3;
    cyc(8);
    chk_reg(KWSC_ADDR_FLAGS, 8'h01, 8'h00);
    press <= 4'h0;
    cyc(6);
  endtask

  // A write while the enable is low must not land
  task automatic t_freeze();
    clk_en <= 1'b0;
    wr(KWSC_ADDR_SELECT, 8'h00);
    clk_en <= 1'b1;
    chk_reg(KWSC_ADDR_SELECT, 8'h0F, 8'h01);
  endtask

  task automatic t_halt();
    strap <= 1'b1;
    wr(KWSC_ADDR_PCC, 8'h01);
    cyc(4);
    pulse(1'b0);
    `CHK(pwr.cpu_clk_en, 1'b0)
    `CHK(pwr.osc_en, 1'b1)
    chk_reg(KWSC_ADDR_PCC, 8'h0C, 8'h04);
    chk_reg(KWSC_ADDR_SELECT, 8'h0F, 8'h01);
    press <= 4'h8;
    cyc(6);
    press <= 4'h0;
    cyc(6);
    chk_reg(KWSC_ADDR_FLAGS, 8'h03, 8'h01);
    `CHK(pwr.cpu_clk_en, 1'b0)
    wr(KWSC_ADDR_FLAGS, 8'h03);
    cyc(2);
    `CHK(pwr.cpu_clk_en, 1'b1)
    wr(KWSC_ADDR_FLAGS, 8'h00);
  endtask

  task automatic t_stop_krst();
    int n;
    wr(KWSC_ADDR_FLAGS, 8'h02);
    wr(KWSC_ADDR_IRQ_ST, 8'h07);
    pulse(1'b1);
    `CHK(pwr.osc_en, 1'b0)
    `CHK(pwr.cpu_clk_en, 1'b0)
    chk_reg(KWSC_ADDR_PCC, 8'h0C, 8'h08);
    press <= 4'h2;
    n = 0;
    repeat (20) begin
      cyc(1);
      if (pwr.sys_reset === 1'b1) n++;
    end
    press <= 4'h0;
    `CHK(n, int'(KWSC_KRST_CYC))
    `CHK(pwr.cpu_clk_en, 1'b1)
    `CHK(pwr.release_evt, 1'b1)
    chk_reg(KWSC_ADDR_FLAGS, 8'h03, 8'h02);
    chk_reg(KWSC_ADDR_IRQ_ST, 8'h02, 8'h02);
    cyc(6);
  endtask

  task automatic t_stop_irq();
    int n;
    strap <= 1'b0;
    wr(KWSC_ADDR_FLAGS, 8'h02);
    pulse(1'b1);
    press <= 4'h1;
    cyc(3);
    wait_run(n);
    `CHK(n >= WAITC && n <= WAITC + 2, 1'b1)
    `CHK(pwr.osc_en, 1'b1)
    press <= 4'h0;
    chk_reg(KWSC_ADDR_FLAGS, 8'h01, 8'h01);
    wr(KWSC_ADDR_FLAGS, 8'h00);
  endtask

  task automatic t_pending();
    int n;
    other_irq_pending <= 1'b1;
    pulse(1'b0);
    cyc(2);
    `CHK(pwr.cpu_clk_en, 1'b1)
    pulse(1'b1);
    wait_run(n);
    `CHK(n >= WAITC && n <= WAITC + 2, 1'b1)
    other_irq_pending <= 1'b0;
  endtask

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    bus = '0;
    press = 4'h0;
    strap = 1'b0;
    stop_exec = 1'b0;
    halt_exec = 1'b0;
    other_irq_pending = 1'b0;
    clk_en = 1'b1;
    error_cnt = 0;
    check_count = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(2);
    t_reset();
    t_edge();
    t_irq();
    t_block();
    t_freeze();
    t_halt();
    t_stop_krst();
    t_stop_irq();
    t_pending();
    finish_test();
  end
endmodule

`default_nettype wire

/* File: rtl/kwsc_edge.sv */
// Key falling-edge detector: one pulse per selected falling edge seen while all keys were high.
// Assumes synchronised key levels on ref_clk.
`default_nettype none

module kwsc_edge
  import kwsc_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Keys and select
  input  wire logic [3:0] key_level,
  input  wire logic [3:0] key_edge_select_register,
  output logic            key_test_source
);
  import kwsc_pkg::*;
  logic [3:0] prev_reg;
  logic [3:0] fall;
  logic       any_low_other;

  // Keys are wired together: all must be high before for an edge to count
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_fall
      assign fall[g] = prev_reg[g] & ~key_level[g];
    end
  endgenerate

  always_comb begin
    any_low_other = ~(&prev_reg);
  end

  assign key_test_source = (|fall) & ~any_low_other &
                           (key_edge_select_register == KWSC_SEL_ALL_KEYS);

  // Previous level register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 4'hF;
    end else if (clk_en) begin
      prev_reg <= key_level;
    end
  end

  // A key seen low on the last enabled edge must mask every edge now
  property p_block_low;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !(&key_level) |=> !key_test_source;
  endproperty
  a_block_low: assert property (p_block_low) else $error("edge passed while key low");

  // Any select value but the all-keys code keeps detection off
  property p_sel_gate;
    @(posedge ref_clk) disable iff (!rst_n)
    key_edge_select_register != KWSC_SEL_ALL_KEYS |-> !key_test_source;
  endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("edge passed with keys unselected");
endmodule

`default_nettype wire

/* File: rtl/kwsc_pkg.sv */
// Package for the key wake-up and standby control block: constants, types.
// Assumes a single ref_clk domain at 125 MHz and an active-low async reset.
`default_nettype none

package kwsc_pkg;
  // Register map on the plain port
  localparam logic [3:0] KWSC_ADDR_PCC    = 4'h0;
  localparam logic [3:0] KWSC_ADDR_SELECT = 4'h1;
  localparam logic [3:0] KWSC_ADDR_FLAGS  = 4'h2;
  localparam logic [3:0] KWSC_ADDR_IRQ_ST = 4'h3;
  localparam logic [3:0] KWSC_ADDR_IRQ_MK = 4'h4;
  // Field positions
  localparam int KWSC_PCC_STOP_BIT = 3;
  localparam int KWSC_PCC_HALT_BIT = 2;
  localparam int KWSC_FLAG_REQ_BIT = 0;
  localparam int KWSC_FLAG_EN_BIT  = 1;
  localparam int KWSC_EVT_EDGE     = 0;
  localparam int KWSC_EVT_KRST     = 1;
  localparam int KWSC_EVT_WAKE     = 2;
  // Edge select value that routes all four keys
  localparam logic [3:0] KWSC_SEL_ALL_KEYS = 4'h1;
  // Reset values
  localparam logic [3:0] KWSC_SEL_RESET = 4'h0;
  localparam logic [3:0] KWSC_PCC_RESET = 4'h0;
  // Oscillation stabilisation wait
  localparam int KWSC_CLK_MHZ     = 125;
  localparam int KWSC_OSC_WAIT_US = 56;
  localparam int KWSC_OSC_WAIT_CYC = KWSC_OSC_WAIT_US * KWSC_CLK_MHZ;
  localparam logic [13:0] KWSC_CNT_ZERO = 14'h0000;
  // Key reset pulse length
  localparam logic [3:0] KWSC_KRST_CYC = 4'h4;

  typedef enum logic [1:0] {KWSC_RUN, KWSC_HALT, KWSC_STOP, KWSC_WAIT} kwsc_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } kwsc_bus_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic osc_en;
    logic sys_reset;
    logic release_evt;
  } kwsc_pwr_s;
endpackage

`default_nettype wire

/* File: rtl/kwsc_sync.sv */
// Two-flop synchroniser bank for the key and key-reset-enable pins.
// Assumes pins are asynchronous to ref_clk.
`default_nettype none

module kwsc_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second; keys idle high after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '1;
      pin_sync <= '1;
    end else if (clk_en) begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule

`default_nettype wire

/* File: rtl/kwsc_top.sv */
// Key wake-up and standby control: key test request, key reset, STOP/HALT.
// Assumes registers are reached over a plain strobe port on ref_clk and
// that the interrupt controller supplies its own pending-enabled level.
`default_nettype none

module kwsc_top
  import kwsc_pkg::*;
#(
  parameter int OSC_WAIT_CYC = KWSC_OSC_WAIT_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Register port
  input  wire kwsc_pkg::kwsc_bus_s bus,
  output logic [7:0]      rdata,
  // Key pins
  input  wire logic       key_return_input_0,
  input  wire logic       key_return_input_1,
  input  wire logic       key_return_input_2,
  input  wire logic       key_return_input_3,
  input  wire logic       key_reset_enable_pin,
  // Processor side
  input  wire logic       stop_exec,
  input  wire logic       halt_exec,
  input  wire logic       other_irq_pending,
  // Power and interrupt outputs
  output kwsc_pkg::kwsc_pwr_s pwr,
  output logic            irq
);
  import kwsc_pkg::*;

  typedef struct packed {
    kwsc_mode_e  mode;
    logic [3:0]  processor_clock_control;
    logic [3:0]  sel;
    logic        req;
    logic        en;
    logic [2:0]  st;
    logic [2:0]  mk;
    logic [13:0] cnt;
    logic [3:0]  krst;
    logic [7:0]  rdata;
  } kwsc_state_s;

  kwsc_state_s state_reg;
  kwsc_state_s state_next;

  logic [4:0] pin_sync;
  logic       key_test_source;
  logic       key_reset_enable_pin_s;
  logic       release_lvl;
  logic       key_reset_hit;
  logic       edge_sets_flag;
  logic [2:0] evt;

  // Synchronise keys and enable pin before any logic reads them
  kwsc_sync #(.W(5)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .pin_in   ({key_reset_enable_pin, key_return_input_3, key_return_input_2,
                key_return_input_1, key_return_input_0}),
    .pin_sync (pin_sync)
  );
  assign key_reset_enable_pin_s = pin_sync[4];

  kwsc_edge u_edge (
    .ref_clk                  (ref_clk),
    .rst_n                    (rst_n),
    .clk_en                   (clk_en),
    .key_level                (pin_sync[3:0]),
    .key_edge_select_register (state_reg.sel),
    .key_test_source          (key_test_source)
  );

  // Edge routing: reset wins only in STOP with the pin high
  assign key_reset_hit  = key_test_source & (state_reg.mode == KWSC_STOP) & key_reset_enable_pin_s;
  assign edge_sets_flag = key_test_source & ~key_reset_hit;
  // Release needs both flags; other sources arrive as one level
  assign release_lvl = (state_reg.req & state_reg.en) | other_irq_pending;

  // Next-state logic
  always_comb begin
    state_next       = state_reg;
    state_next.rdata = 8'h00;
    evt              = 3'h0;

    // Request flag: hardware set wins over software clear
    if (bus.wr && bus.addr == KWSC_ADDR_FLAGS) begin
      state_next.req = bus.wdata[KWSC_FLAG_REQ_BIT];
      state_next.en  = bus.wdata[KWSC_FLAG_EN_BIT];
    end
    if (edge_sets_flag) begin
      state_next.req = 1'b1;
      evt[KWSC_EVT_EDGE] = 1'b1;
    end

    // Edge select is one four-bit write
    if (bus.wr && bus.addr == KWSC_ADDR_SELECT) begin
      state_next.sel = bus.wdata[3:0];
    end
    if (bus.wr && bus.addr == KWSC_ADDR_PCC) begin
      state_next.processor_clock_control[1:0] = bus.wdata[1:0];
    end
    if (bus.wr && bus.addr == KWSC_ADDR_IRQ_MK) begin
      state_next.mk = bus.wdata[2:0];
    end

    // Key reset pulse stretch
    if (state_reg.krst != 4'h0) begin
      state_next.krst = state_reg.krst - 4'h1;
    end

    // Standby mode sequencer; register writes still land while asleep
    case (state_reg.mode)
      KWSC_RUN: begin
        if (stop_exec) begin
          state_next.processor_clock_control[KWSC_PCC_STOP_BIT] = 1'b1;
          state_next.mode = KWSC_STOP;
        end else if (halt_exec) begin
          state_next.processor_clock_control[KWSC_PCC_HALT_BIT] = 1'b1;
          state_next.mode = KWSC_HALT;
        end
      end
      KWSC_HALT: begin
        if (release_lvl) begin
          state_next.processor_clock_control[KWSC_PCC_HALT_BIT] = 1'b0;
          state_next.mode = KWSC_RUN;
          evt[KWSC_EVT_WAKE] = 1'b1;
        end
      end
      KWSC_STOP: begin
        if (key_reset_hit) begin
          // Enable flags untouched: only mode, STOP bit, reset pulse and key-reset status change
          state_next.processor_clock_control[KWSC_PCC_STOP_BIT] = 1'b0;
          state_next.mode = KWSC_RUN;
          state_next.krst = KWSC_KRST_CYC;
          evt[KWSC_EVT_KRST] = 1'b1;
        end else if (release_lvl) begin
          state_next.cnt  = 14'(OSC_WAIT_CYC - 1);
          state_next.mode = KWSC_WAIT;
        end
      end
      KWSC_WAIT: begin
        if (state_reg.cnt == KWSC_CNT_ZERO) begin
          state_next.processor_clock_control[KWSC_PCC_STOP_BIT] = 1'b0;
          state_next.mode = KWSC_RUN;
          evt[KWSC_EVT_WAKE] = 1'b1;
        end else begin
          state_next.cnt = state_reg.cnt - 14'h0001;
        end
      end
      default: state_next.mode = KWSC_RUN;
    endcase

    // Sticky status, set wins over write-one-to-clear
    if (bus.wr && bus.addr == KWSC_ADDR_IRQ_ST) begin
      state_next.st = state_reg.st & ~bus.wdata[2:0];
    end
    state_next.st = state_next.st | evt;

    // Read data one cycle after the strobe
    if (bus.rd) begin
      case (bus.addr)
        KWSC_ADDR_PCC:    state_next.rdata = {4'h0, state_reg.processor_clock_control};
        KWSC_ADDR_SELECT: state_next.rdata = {4'h0, state_reg.sel};
        KWSC_ADDR_FLAGS:  state_next.rdata = {5'h00, key_reset_enable_pin_s, state_reg.en, state_reg.req};
        KWSC_ADDR_IRQ_ST: state_next.rdata = {5'h00, state_reg.st};
        KWSC_ADDR_IRQ_MK: state_next.rdata = {5'h00, state_reg.mk};
        default:          state_next.rdata = 8'h00;
      endcase
    end
  end

  // State register; clk_en low freezes everything
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= '0;
      state_reg.mode  <= KWSC_RUN;
      state_reg.sel   <= KWSC_SEL_RESET;
      state_reg.processor_clock_control   <= KWSC_PCC_RESET;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Outputs: oscillator off only in STOP, CPU clock off in any standby
  always_comb begin
    pwr.osc_en      = (state_reg.mode != KWSC_STOP);
    pwr.cpu_clk_en  = (state_reg.mode == KWSC_RUN);
    pwr.sys_reset   = (state_reg.krst != 4'h0);
    pwr.release_evt = state_reg.st[KWSC_EVT_WAKE] | state_reg.st[KWSC_EVT_KRST];
  end
  assign rdata = state_reg.rdata;
  assign irq   = |(state_reg.st & state_reg.mk);

  // Checks
  property p_req_set;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && edge_sets_flag |=> state_reg.req;
  endproperty
  a_req_set: assert property (p_req_set) else $error("request flag not set");

  property p_req_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg.req && !(clk_en && bus.wr && bus.addr == KWSC_ADDR_FLAGS) |=> state_reg.req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request flag dropped alone");

  property p_release;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && state_reg.mode == KWSC_HALT && state_reg.req && state_reg.en |=> state_reg.mode == KWSC_RUN;
  endproperty
  a_release: assert property (p_release) else $error("halt not released");

  property p_krst;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && key_reset_hit |=> pwr.sys_reset && state_reg.mode == KWSC_RUN && $stable(state_reg.req);
  endproperty
  a_krst: assert property (p_krst) else $error("key reset missing");

  property p_no_krst;
    @(posedge ref_clk) disable iff (!rst_n)
    key_test_source && !(state_reg.mode == KWSC_STOP && key_reset_enable_pin_s) |-> !key_reset_hit;
  endproperty
  a_no_krst: assert property (p_no_krst) else $error("key reset outside stop");

  property p_en_keep;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && key_reset_hit |=> $stable(state_reg.en);
  endproperty
  a_en_keep: assert property (p_en_keep) else $error("enable changed by key reset");

  property p_osc;
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg.mode == KWSC_HALT |-> pwr.osc_en && !pwr.cpu_clk_en;
  endproperty
  a_osc: assert property (p_osc) else $error("halt clocks wrong");

  property p_stop_osc;
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg.mode == KWSC_STOP |-> !pwr.osc_en;
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("oscillator runs in stop");

  property p_wait;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && state_reg.mode == KWSC_STOP && release_lvl && !key_reset_hit |=> state_reg.mode == KWSC_WAIT;
  endproperty
  a_wait: assert property (p_wait) else $error("no stabilisation wait");

  property p_stop_entry;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && state_reg.mode == KWSC_RUN && stop_exec |=> state_reg.processor_clock_control[KWSC_PCC_STOP_BIT];
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop bit not set");

  c_halt_wake: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg.mode == KWSC_HALT ##1 state_reg.mode == KWSC_RUN);
  c_krst: cover property (@(posedge ref_clk) disable iff (!rst_n) key_reset_hit);
  c_wait_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg.mode == KWSC_WAIT ##1 state_reg.mode == KWSC_RUN);
endmodule

`default_nettype wire
